// ---- hw/tpx_pkg.sv ----
// Constants, opcodes and carrier types for the timer and port instruction executor
package tpx_pkg;

  // ==========================================================
  // Operand widths
  localparam int NIB_W = 4;
  localparam int PD_W  = 8;

  // ==========================================================
  // Opcodes of this instruction group
  localparam logic [9:0] OP_READ_TIMER_CTL_FIVE      = 10'h24f;
  localparam logic [9:0] OP_WRITE_TIMER_CTL_FIVE     = 10'h212;
  localparam logic [9:0] OP_READ_TIMER_CTL_SIX       = 10'h250;
  localparam logic [9:0] OP_WRITE_TIMER_CTL_SIX      = 10'h213;
  localparam logic [9:0] OP_READ_PRESCALE_COUNT      = 10'h275;
  localparam logic [9:0] OP_WRITE_PRESCALE_BOTH      = 10'h235;
  localparam logic [9:0] OP_READ_TIMER_ONE           = 10'h270;
  localparam logic [9:0] OP_READ_TIMER_FOUR          = 10'h273;
  localparam logic [9:0] OP_WRITE_TIMER_ONE_BOTH     = 10'h230;
  localparam logic [9:0] OP_WRITE_TIMER_TWO_BOTH     = 10'h231;
  localparam logic [9:0] OP_WRITE_TIMER_THREE_BOTH   = 10'h232;
  localparam logic [9:0] OP_WRITE_TIMER_FOUR_BOTH    = 10'h233;
  localparam logic [9:0] OP_WRITE_TIMER_FOUR_HIGH_RL = 10'h237;
  localparam logic [9:0] OP_WRITE_TIMER_ONE_RELOAD   = 10'h23f;
  localparam logic [9:0] OP_WRITE_TIMER_THREE_RELOAD = 10'h23b;
  localparam logic [9:0] OP_COPY_LOW_RL_TO_T4        = 10'h297;
  localparam logic [9:0] OP_TEST_TIMER_ONE_FLAG      = 10'h280;
  localparam logic [9:0] OP_TEST_TIMER_FOUR_FLAG     = 10'h283;
  localparam logic [9:0] OP_INPUT_PORT_ZERO          = 10'h260;
  localparam logic [9:0] OP_INPUT_PORT_ONE           = 10'h261;
  localparam logic [9:0] OP_INPUT_PORT_TWO           = 10'h262;
  localparam logic [9:0] OP_INPUT_PORT_THREE         = 10'h263;
  localparam logic [9:0] OP_INPUT_PORT_SIX           = 10'h266;
  localparam logic [9:0] OP_OUTPUT_PORT_ZERO         = 10'h220;
  localparam logic [9:0] OP_OUTPUT_PORT_ONE          = 10'h221;
  localparam logic [9:0] OP_OUTPUT_PORT_TWO          = 10'h222;
  localparam logic [9:0] OP_OUTPUT_PORT_THREE        = 10'h223;
  localparam logic [9:0] OP_OUTPUT_PORT_SIX          = 10'h226;
  localparam logic [9:0] OP_SET_ALL_BIT_PORT         = 10'h011;
  localparam logic [9:0] OP_CLEAR_BIT_PORT_BIT       = 10'h014;
  localparam logic [9:0] OP_SET_BIT_PORT_BIT         = 10'h015;
  localparam logic [9:0] OP_TEST_BIT_PORT_ZERO       = 10'h024;
  localparam logic [9:0] OP_TEST_BIT_PORT_ZERO_ALT   = 10'h02b;
  localparam logic [9:0] OP_READ_PULLUP_ZERO         = 10'h257;
  localparam logic [9:0] OP_WRITE_PULLUP_ZERO        = 10'h22d;
  localparam logic [9:0] OP_READ_PULLUP_ONE          = 10'h25e;
  localparam logic [9:0] OP_WRITE_PULLUP_ONE         = 10'h22e;

  // ==========================================================
  // Interrupt enable bits guarding the flag tests
  localparam int IEN_T1_BIT = 2;
  localparam int IEN_T2_BIT = 3;
  localparam int IEN_T3_BIT = 0;
  localparam int IEN_T4_BIT = 1;

  // ==========================================================
  // APB register map, byte addresses
  localparam int          APB_AW      = 12;
  localparam logic [11:0] OFF_IRQ_CTL = 12'h000;
  localparam logic [11:0] OFF_STATUS  = 12'h004;
  localparam logic [11:0] OFF_CTL_RD  = 12'h008;
  localparam logic [3:0]  RST_NIB     = 4'h0;
  localparam logic [7:0]  RST_BYTE    = 8'h00;

  // ==========================================================
  // Carrier types
  typedef enum logic [0:0] {
    TPX_AP_IDLE = 1'b0,
    TPX_AP_ANS  = 1'b1
  } tpx_apb_st_t;

  typedef struct packed {
    logic             valid;
    logic [9:0]       code;
    logic [NIB_W-1:0] a;
    logic [NIB_W-1:0] b;
    logic [NIB_W-1:0] y;
  } tpx_instr_t;

  typedef struct packed {
    logic [7:0] ps_cnt;
    logic [7:0] ps_rld;
    logic [7:0] cnt1;
    logic [7:0] cnt2;
    logic [7:0] cnt3;
    logic [7:0] cnt4;
    logic [7:0] rld1;
    logic [7:0] rld2;
    logic [7:0] rld3;
    logic [7:0] rld4l;
    logic [7:0] rld4h;
  } tpx_tmr_t;

  typedef struct packed {
    logic [3:0]      p0;
    logic [3:0]      p1;
    logic [2:0]      p2;
    logic [1:0]      p3;
    logic [3:0]      p6;
    logic [PD_W-1:0] pd;
  } tpx_pins_t;

endpackage

// ---- hw/tpx_top.sv ----
// Executor for the timer and port transfer instructions, with an APB status slave
//
// Operation
// RULE1: Copy timer control five and six to and from the accumulator.
// RULE2: Prescaler read puts high nibble in B, low nibble in A.
// RULE3: Prescaler write loads B:A into prescaler counter and reload together.
// RULE4: Timer reads for timers one to four return high in B, low in A.
// RULE5: Timer one to three writes load B:A into counter and reload.
// RULE6: Timer four write loads counter and low reload, high reload kept.
// RULE7: Timer four high reload write leaves the timer four counter alone.
// RULE8: Timer one and three reload-only writes leave the counter alone.
// RULE9: Copy timer four low reload into the timer four counter.
// RULE10: Timer one flag test skips and clears when enable bit two is zero.
// RULE11: Timer two flag test skips and clears when enable bit three is zero.
// RULE12: Timer three flag test skips and clears when second bit zero is zero.
// RULE13: Timer four flag test skips and clears when second bit one is zero.
// RULE14: Ports zero, one, six read pins into A and latch A.
// RULE15: Port two reads into A bits two..zero with bit three zero.
// RULE16: Port three reads and writes accumulator bits one and zero.
// RULE17: Set-all drives every port D latch to one.
// RULE18: Bit clear zeroes the port D latch chosen by Y in 0..7.
// RULE19: Bit set raises the port D latch chosen by Y in 0..7.
// RULE20: Bit test skips when the selected port D bit reads zero.
// RULE21: Copy both pull-up control registers to and from the accumulator.
// RULE22: With its enable bit set a flag test neither skips nor clears.
// RULE23: Each instruction completes in one cycle, visible to the next.
`timescale 1ns/1ns
module tpx_top (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Instruction from decode
  input  wire tpx_pkg::tpx_instr_t   instr,
  // Results to the accumulator datapath
  output logic                       acc_wr,
  output logic [3:0]                 acc_data,
  output logic                       b_wr,
  output logic [3:0]                 b_data,
  output logic                       skip_next,
  // Timer hardware
  input  wire logic [3:0]            timer_evt,
  output tpx_pkg::tpx_tmr_t          timers,
  output logic [3:0]                 timer_flags,
  output logic [3:0]                 timer_ctl_five,
  output logic [3:0]                 timer_ctl_six,
  // Port pins and latches
  input  wire tpx_pkg::tpx_pins_t    pins_in,
  output tpx_pkg::tpx_pins_t         pins_out,
  output logic [3:0]                 pullup_ctl_zero,
  output logic [3:0]                 pullup_ctl_one
);
  import tpx_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    tpx_apb_st_t apb_st;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        acc_wr;
    logic [3:0]  acc;
    logic        b_wr;
    logic [3:0]  b;
    logic        skip;
    tpx_tmr_t    tmr;
    logic [3:0]  flags;
    logic [3:0]  ctl5;
    logic [3:0]  ctl6;
    logic [3:0]  pu0;
    logic [3:0]  pu1;
    logic [3:0]  irq1;
    logic [3:0]  irq2;
    tpx_pins_t   pout;
  } tpx_state_t;

  tpx_state_t state_reg;
  tpx_state_t state_next;
  logic [3:0] ien;

  // ==========================================================
  // Helpers
  // Address decode shared by read mux and error answer
  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    case (a)
      OFF_IRQ_CTL: reg_sel = 2'h0;
      OFF_STATUS:  reg_sel = 2'h1;
      OFF_CTL_RD:  reg_sel = 2'h2;
      default:     reg_sel = 2'h3;
    endcase
  endfunction

  // Byte from the B:A register pair
  function automatic logic [7:0] pair(input logic [3:0] hi, input logic [3:0] lo);
    pair = {hi, lo};
  endfunction

  // Enable bits guarding the four flag tests, in timer order
  assign ien = {state_reg.irq2[IEN_T4_BIT], state_reg.irq2[IEN_T3_BIT],
                state_reg.irq1[IEN_T2_BIT], state_reg.irq1[IEN_T1_BIT]};

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0] ab;
    logic [7:0] rd;
    logic       yok;
    ab = pair(instr.b, instr.a);
    rd = 8'h00;
    yok = (instr.y < 4'(PD_W));
    state_next = state_reg;
    state_next.acc_wr = 1'b0;
    state_next.b_wr = 1'b0;
    state_next.skip = 1'b0;

    // APB: answer is prepared in setup so pready and prdata come from flops
    case (state_reg.apb_st)
      TPX_AP_IDLE: begin
        if (psel && !penable) begin
          state_next.apb_st = TPX_AP_ANS;
          state_next.pready = 1'b1;
          state_next.pslverr = (reg_sel(paddr) == 2'h3);
          case (reg_sel(paddr))
            2'h0:    state_next.prdata = {24'h0, state_reg.irq2, state_reg.irq1};
            2'h1:    state_next.prdata = {16'h0, state_reg.pout.pd, 4'h0,
                                          state_reg.flags};
            2'h2:    state_next.prdata = {16'h0, state_reg.pu1, state_reg.pu0,
                                          state_reg.ctl6, state_reg.ctl5};
            default: state_next.prdata = 32'h0;
          endcase
        end
      end
      TPX_AP_ANS: begin
        if (psel && penable) begin
          state_next.apb_st = TPX_AP_IDLE;
          state_next.pready = 1'b0;
          state_next.pslverr = 1'b0;
          state_next.prdata = 32'h0;
          // Only the enable register is writable; status words ignore writes
          if (pwrite && reg_sel(paddr) == 2'h0) begin
            state_next.irq1 = pwdata[3:0];
            state_next.irq2 = pwdata[7:4];
          end
        end
      end
      default: state_next.apb_st = TPX_AP_IDLE;
    endcase

    // Instruction execution, one cycle each, results land at the next edge
    if (instr.valid) begin
      case (instr.code)
        OP_READ_TIMER_CTL_FIVE: begin
          state_next.acc_wr = 1'b1; // RULE1
          state_next.acc = state_reg.ctl5;
        end
        OP_READ_TIMER_CTL_SIX: begin
          state_next.acc_wr = 1'b1; // RULE1
          state_next.acc = state_reg.ctl6;
        end
        OP_WRITE_TIMER_CTL_FIVE: state_next.ctl5 = instr.a; // RULE1
        OP_WRITE_TIMER_CTL_SIX:  state_next.ctl6 = instr.a; // RULE1
        OP_READ_PRESCALE_COUNT: begin
          state_next.b_wr = 1'b1; // RULE2
          state_next.acc_wr = 1'b1;
          {state_next.b, state_next.acc} = state_reg.tmr.ps_cnt;
        end
        OP_WRITE_PRESCALE_BOTH: begin
          state_next.tmr.ps_cnt = ab; // RULE3
          state_next.tmr.ps_rld = ab;
        end
        OP_READ_TIMER_ONE, OP_READ_TIMER_ONE + 10'h001,
        OP_READ_TIMER_ONE + 10'h002, OP_READ_TIMER_FOUR: begin
          case (instr.code[1:0])
            2'h0:    rd = state_reg.tmr.cnt1;
            2'h1:    rd = state_reg.tmr.cnt2;
            2'h2:    rd = state_reg.tmr.cnt3;
            default: rd = state_reg.tmr.cnt4;
          endcase
          state_next.b_wr = 1'b1; // RULE4
          state_next.acc_wr = 1'b1;
          {state_next.b, state_next.acc} = rd;
        end
        OP_WRITE_TIMER_ONE_BOTH: begin
          state_next.tmr.cnt1 = ab; // RULE5
          state_next.tmr.rld1 = ab;
        end
        OP_WRITE_TIMER_TWO_BOTH: begin
          state_next.tmr.cnt2 = ab; // RULE5
          state_next.tmr.rld2 = ab;
        end
        OP_WRITE_TIMER_THREE_BOTH: begin
          state_next.tmr.cnt3 = ab; // RULE5
          state_next.tmr.rld3 = ab;
        end
        OP_WRITE_TIMER_FOUR_BOTH: begin
          state_next.tmr.cnt4 = ab; // RULE6
          state_next.tmr.rld4l = ab;
        end
        OP_WRITE_TIMER_FOUR_HIGH_RL: state_next.tmr.rld4h = ab; // RULE7
        OP_WRITE_TIMER_ONE_RELOAD:   state_next.tmr.rld1 = ab;  // RULE8
        OP_WRITE_TIMER_THREE_RELOAD: state_next.tmr.rld3 = ab;  // RULE8
        OP_COPY_LOW_RL_TO_T4: state_next.tmr.cnt4 = state_reg.tmr.rld4l; // RULE9
        OP_TEST_TIMER_ONE_FLAG, OP_TEST_TIMER_ONE_FLAG + 10'h001,
        OP_TEST_TIMER_ONE_FLAG + 10'h002, OP_TEST_TIMER_FOUR_FLAG: begin
          // A set enable turns the test into a no-op
          if (!ien[instr.code[1:0]] && state_reg.flags[instr.code[1:0]]) begin
            state_next.skip = 1'b1; // RULE10 RULE11 RULE12 RULE13 RULE22
            state_next.flags[instr.code[1:0]] = 1'b0;
          end
        end
        OP_INPUT_PORT_ZERO: begin
          state_next.acc_wr = 1'b1; // RULE14
          state_next.acc = pins_in.p0;
        end
        OP_INPUT_PORT_ONE: begin
          state_next.acc_wr = 1'b1; // RULE14
          state_next.acc = pins_in.p1;
        end
        OP_INPUT_PORT_SIX: begin
          state_next.acc_wr = 1'b1; // RULE14
          state_next.acc = pins_in.p6;
        end
        OP_INPUT_PORT_TWO: begin
          state_next.acc_wr = 1'b1; // RULE15
          state_next.acc = {1'b0, pins_in.p2};
        end
        OP_INPUT_PORT_THREE: begin
          state_next.acc_wr = 1'b1; // RULE16
          state_next.acc = {2'b00, pins_in.p3};
        end
        OP_OUTPUT_PORT_ZERO:  state_next.pout.p0 = instr.a;      // RULE14
        OP_OUTPUT_PORT_ONE:   state_next.pout.p1 = instr.a;      // RULE14
        OP_OUTPUT_PORT_SIX:   state_next.pout.p6 = instr.a;      // RULE14
        OP_OUTPUT_PORT_TWO:   state_next.pout.p2 = instr.a[2:0]; // RULE15
        OP_OUTPUT_PORT_THREE: state_next.pout.p3 = instr.a[1:0]; // RULE16
        OP_SET_ALL_BIT_PORT:  state_next.pout.pd = '1;           // RULE17
        // Y outside 0..7 is undefined use; it leaves the latches alone
        OP_CLEAR_BIT_PORT_BIT: if (yok) state_next.pout.pd[instr.y[2:0]] = 1'b0; // RULE18
        OP_SET_BIT_PORT_BIT:   if (yok) state_next.pout.pd[instr.y[2:0]] = 1'b1; // RULE19
        OP_TEST_BIT_PORT_ZERO, OP_TEST_BIT_PORT_ZERO_ALT: begin
          // Pin level is tested so an externally pulled bit is seen
          if (yok) state_next.skip = !pins_in.pd[instr.y[2:0]]; // RULE20
        end
        OP_READ_PULLUP_ZERO: begin
          state_next.acc_wr = 1'b1; // RULE21
          state_next.acc = state_reg.pu0;
        end
        OP_READ_PULLUP_ONE: begin
          state_next.acc_wr = 1'b1; // RULE21
          state_next.acc = state_reg.pu1;
        end
        OP_WRITE_PULLUP_ZERO: state_next.pu0 = instr.a; // RULE21
        OP_WRITE_PULLUP_ONE:  state_next.pu1 = instr.a; // RULE21
        default: ;
      endcase
    end

    // A timer event in the clearing cycle wins so no underflow is lost
    for (int i = 0; i < 4; i++) begin
      if (timer_evt[i]) state_next.flags[i] = 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.apb_st <= TPX_AP_IDLE;
      state_reg.ctl5 <= RST_NIB;
      state_reg.ctl6 <= RST_NIB;
      state_reg.tmr.ps_cnt <= RST_BYTE;
    end else begin
      state_reg <= state_next; // RULE23
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  assign pready          = state_reg.pready;
  assign prdata          = state_reg.prdata;
  assign pslverr         = state_reg.pslverr;
  assign acc_wr          = state_reg.acc_wr;
  assign acc_data        = state_reg.acc;
  assign b_wr            = state_reg.b_wr;
  assign b_data          = state_reg.b;
  assign skip_next       = state_reg.skip;
  assign timers          = state_reg.tmr;
  assign timer_flags     = state_reg.flags;
  assign timer_ctl_five  = state_reg.ctl5;
  assign timer_ctl_six   = state_reg.ctl6;
  assign pins_out        = state_reg.pout;
  assign pullup_ctl_zero = state_reg.pu0;
  assign pullup_ctl_one  = state_reg.pu1;

  // ==========================================================
  // Assertions
  // Checks rest during reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Guard clear, flag up
  sequence s_t1_hit;
    instr.valid && instr.code == OP_TEST_TIMER_ONE_FLAG && !ien[0] && timer_flags[0];
  endsequence

  // Guard set: a no-op
  sequence s_t1_off;
    instr.valid && instr.code == OP_TEST_TIMER_ONE_FLAG && ien[0];
  endsequence

  // Transfers
  a_ctl_five_rd: assert property (instr.valid && instr.code == OP_READ_TIMER_CTL_FIVE
    |=> acc_wr && acc_data == $past(timer_ctl_five)) else $error("ctl five read"); // RULE1
  a_prescale_rd: assert property (instr.valid && instr.code == OP_READ_PRESCALE_COUNT
    |=> b_wr && acc_wr && {b_data, acc_data} == $past(timers.ps_cnt))
    else $error("prescaler read"); // RULE2
  a_prescale_wr: assert property (instr.valid && instr.code == OP_WRITE_PRESCALE_BOTH
    |=> timers.ps_cnt == {$past(instr.b), $past(instr.a)} && timers.ps_rld == timers.ps_cnt)
    else $error("prescaler write"); // RULE3

  // Timer writes and reloads
  a_t2_wr_both: assert property (instr.valid && instr.code == OP_WRITE_TIMER_TWO_BOTH // RULE5
    |=> timers.cnt2 == {$past(instr.b), $past(instr.a)} && timers.rld2 == timers.cnt2)
    else $error("timer two write");
  a_t4_wr_both: assert property (instr.valid && instr.code == OP_WRITE_TIMER_FOUR_BOTH
    |=> timers.cnt4 == timers.rld4l && $stable(timers.rld4h))
    else $error("timer four write"); // RULE6
  a_t4_high_rl: assert property (instr.valid && instr.code == OP_WRITE_TIMER_FOUR_HIGH_RL
    |=> $stable(timers.cnt4) && timers.rld4h == {$past(instr.b), $past(instr.a)})
    else $error("timer four high reload"); // RULE7
  a_t1_rld_only: assert property (instr.valid && instr.code == OP_WRITE_TIMER_ONE_RELOAD
    |=> $stable(timers.cnt1)) else $error("reload write touched counter"); // RULE8
  a_t4_copy: assert property (instr.valid && instr.code == OP_COPY_LOW_RL_TO_T4
    |=> timers.cnt4 == $past(timers.rld4l)) else $error("low reload copy"); // RULE9

  // Flag tests
  a_t1_flag_hit: assert property (s_t1_hit ##0 !timer_evt[0]
    |=> skip_next && !timer_flags[0]) else $error("flag test hit"); // RULE10
  a_t1_flag_off: assert property (s_t1_off
    |=> !skip_next && timer_flags[0] == ($past(timer_flags[0]) | $past(timer_evt[0])))
    else $error("disabled flag test acted"); // RULE22
  a_flag_set_wins: assert property (timer_evt[3] |=> timer_flags[3])
    else $error("flag event lost"); // RULE13

  // Ports
  a_port_two_rd: assert property (instr.valid && instr.code == OP_INPUT_PORT_TWO
    |=> acc_wr && acc_data == {1'b0, $past(pins_in.p2)}) else $error("port two read"); // RULE15
  a_port_three_rd: assert property (instr.valid && instr.code == OP_INPUT_PORT_THREE // RULE16
    |=> acc_wr && acc_data == {2'b00, $past(pins_in.p3)}) else $error("port three read");
  a_set_all: assert property (instr.valid && instr.code == OP_SET_ALL_BIT_PORT // RULE17
    |=> pins_out.pd == '1) else $error("port set all");
  a_pullup_wr: assert property (instr.valid && instr.code == OP_WRITE_PULLUP_ZERO // RULE21
    |=> pullup_ctl_zero == $past(instr.a)) else $error("pull-up write");
  a_bit_set: assert property (instr.valid && instr.code == OP_SET_BIT_PORT_BIT
    && instr.y < 4'(PD_W) |=> pins_out.pd[$past(instr.y[2:0])])
    else $error("port bit set"); // RULE19
  a_bit_test: assert property (instr.valid && instr.code == OP_TEST_BIT_PORT_ZERO
    && instr.y < 4'(PD_W) |=> skip_next == !$past(pins_in.pd[instr.y[2:0]]))
    else $error("port bit test"); // RULE20

endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the timer and port instruction executor
`timescale 1ns/1ns
module tb_top;
  import tpx_pkg::*;
  // ==========================================================
  // Signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  tpx_instr_t  instr;
  logic        acc_wr, b_wr, skip_next;
  logic [3:0]  acc_data, b_data, timer_evt, timer_flags, ra, acc_q;
  logic [3:0]  ctl5, ctl6, pu0, pu1;
  logic [3:0]  r4[4];
  tpx_tmr_t    timers, et;
  tpx_pins_t   pins_in, pins_out, ep;
  logic [7:0]  skips, nskip, v;
  logic [13:0] e;
  logic [13:0] q[$];
  logic [9:0]  wl[9] = '{10'h235, 10'h230, 10'h231, 10'h232, 10'h233, 10'h237, 10'h23f,
                         10'h23b, 10'h297};
  logic [9:0]  cw[4] = '{10'h212, 10'h213, 10'h22d, 10'h22e};
  logic [9:0]  cr[4] = '{10'h24f, 10'h250, 10'h257, 10'h25e};
  logic [9:0]  pc[5] = '{10'h220, 10'h221, 10'h222, 10'h223, 10'h226};
  int          mismatches, tests_run, seed, i;

  tpx_top u_tpx_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .instr(instr), .acc_wr(acc_wr), .acc_data(acc_data), .b_wr(b_wr),
    .b_data(b_data), .skip_next(skip_next), .timer_evt(timer_evt), .timers(timers),
    .timer_flags(timer_flags), .timer_ctl_five(ctl5), .timer_ctl_six(ctl6),
    .pins_in(pins_in), .pins_out(pins_out), .pullup_ctl_zero(pu0), .pullup_ctl_one(pu1));
  tpx_cpu_model u_tpx_cpu_model (.pclk(pclk), .presetn(presetn), .acc_wr(acc_wr),
    .acc_data(acc_data), .b_wr(b_wr), .b_data(b_data), .skip_next(skip_next),
    .acc_q(acc_q), .skips(skips));

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Drivers; an instruction stays valid until idle, so calls run back to back
  task automatic ex(input logic [9:0] c, input logic [3:0] a, b, y);
    @(posedge pclk);
    instr <= '{1'b1, c, a, b, y};
  endtask
  task automatic idle;
    @(posedge pclk);
    instr.valid <= 1'b0;
    @(negedge pclk);
  endtask
  // Expected values are taken at the call
  task automatic rx(input logic [9:0] c, input logic [1:0] k, input logic [3:0] m, b, a);
    ex(c, 4'h0, 4'h0, 4'h0);
    q.push_back({k, m, b, a});
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask

  // ==========================================================
  // Watcher: each result pulse takes the oldest note; kind 1 carries B, 2 is a skip
  always @(negedge pclk) begin
    if (acc_wr === 1'b1 || skip_next === 1'b1) begin
      e = (q.size() > 0) ? q.pop_front() : 14'h3fff;
      if (skip_next === 1'b1) check(e[13:12], 2'd2);
      else check(acc_data & e[11:8], e[3:0] & e[11:8]);
      if (acc_wr === 1'b1 && e[13:12] == 2'd1) check({b_wr, b_data}, {1'b1, e[7:4]});
    end
  end

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, timer_evt} = '0;
    instr = '0;
    pins_in = '0;
    {mismatches, tests_run, nskip} = '0;
    seed = 32'h4481d8ea;
    et = '0;
    ep = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({timers, timer_flags, pins_out}, '0);
    // Timer writes in all forms, twice over, then the prescaler and the four counters read back
    repeat (2) for (i = 0; i < 9; i++) begin
      v = 8'($random(seed));
      case (wl[i])
        10'h235: {et.ps_cnt, et.ps_rld} = {v, v};
        10'h230: {et.cnt1, et.rld1} = {v, v};
        10'h231: {et.cnt2, et.rld2} = {v, v};
        10'h232: {et.cnt3, et.rld3} = {v, v};
        10'h233: {et.cnt4, et.rld4l} = {v, v};
        10'h237: et.rld4h = v;
        10'h23f: et.rld1 = v;
        10'h23b: et.rld3 = v;
        default: et.cnt4 = et.rld4l;
      endcase
      ex(wl[i], v[3:0], v[7:4], 4'h0);
    end
    rx(OP_READ_PRESCALE_COUNT, 2'd1, 4'hf, et.ps_cnt[7:4], et.ps_cnt[3:0]);
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? et.cnt1 : (i == 1) ? et.cnt2 : (i == 2) ? et.cnt3 : et.cnt4;
      rx(10'h270 + 10'(i), 2'd1, 4'hf, v[7:4], v[3:0]);
    end
    idle();
    check(timers, et);
    // Control and pull-up registers
    for (i = 0; i < 4; i++) begin
      r4[i] = 4'($random(seed));
      ex(cw[i], r4[i], 4'h0, 4'h0);
      rx(cr[i], 2'd0, 4'hf, 4'h0, r4[i]);
    end
    idle();
    check({ctl5, ctl6, pu0, pu1}, {r4[0], r4[1], r4[2], r4[3]});
    // Port latches, then pin reads
    for (i = 0; i < 5; i++) begin
      ra = 4'($random(seed));
      case (i)
        0: ep.p0 = ra;
        1: ep.p1 = ra;
        2: ep.p2 = ra[2:0];
        3: ep.p3 = ra[1:0];
        default: ep.p6 = ra;
      endcase
      ex(pc[i], ra, 4'h0, 4'h0);
    end
    @(posedge pclk) pins_in <= 25'($random(seed));
    @(negedge pclk);
    rx(10'h260, 2'd0, 4'hf, 4'h0, pins_in.p0);
    rx(10'h261, 2'd0, 4'hf, 4'h0, pins_in.p1);
    rx(10'h262, 2'd0, 4'hf, 4'h0, {1'b0, pins_in.p2});
    rx(10'h263, 2'd0, 4'h3, 4'h0, {2'b00, pins_in.p3});
    rx(10'h266, 2'd0, 4'hf, 4'h0, pins_in.p6);
    idle();
    check(pins_out, ep);
    // Port D: set all, out-of-range Y, clear each, set one
    ex(OP_SET_ALL_BIT_PORT, 4'h0, 4'h0, 4'h0);
    ex(OP_CLEAR_BIT_PORT_BIT, 4'h0, 4'h0, 4'h8);
    idle();
    check(pins_out.pd, 8'hff);
    for (i = 0; i < 8; i++) ex(OP_CLEAR_BIT_PORT_BIT, 4'h0, 4'h0, 4'(i));
    idle();
    check(pins_out.pd, 8'h00);
    ex(OP_SET_BIT_PORT_BIT, 4'h0, 4'h0, 4'h8);
    ex(OP_SET_BIT_PORT_BIT, 4'h0, 4'h0, 4'h5);
    idle();
    check(pins_out.pd, 8'h20);
    // Bit tests on pins, both codes, Y of 8 never skips
    for (i = 0; i < 9; i++) begin
      ex(i[0] ? OP_TEST_BIT_PORT_ZERO : OP_TEST_BIT_PORT_ZERO_ALT, 4'h0, 4'h0, 4'(i));
      if (i < 8 && pins_in.pd[i] == 1'b0) begin
        q.push_back(14'h2000);
        nskip++;
      end
    end
    idle();
    // Flag tests: guard bit set gives no effect, guard clear skips and clears
    for (i = 0; i < 4; i++) begin
      @(posedge pclk) timer_evt <= 4'h1 << i;
      @(posedge pclk) timer_evt <= 4'h0;
      apb(1'b1, OFF_IRQ_CTL, 32'h1 << (i + 2));
      ex(10'h280 + 10'(i), 4'h0, 4'h0, 4'h0);
      idle();
      check(timer_flags, 4'h1 << i);
      apb(1'b1, OFF_IRQ_CTL, ~(32'h1 << (i + 2)) & 32'hff);
      ex(10'h280 + 10'(i), 4'h0, 4'h0, 4'h0);
      q.push_back(14'h2000);
      nskip++;
      idle();
      check(timer_flags, 4'h0);
    end
    // Status words over the bus, then an unmapped address
    apb(1'b0, OFF_IRQ_CTL, 32'h0);
    check(rd, 32'hdf);
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd, 32'h2000);
    apb(1'b0, OFF_CTL_RD, 32'h0);
    check(rd, {16'h0, r4[3], r4[2], r4[1], r4[0]});
    apb(1'b0, 12'h00c, 32'h0);
    check({er, rd}, {1'b1, 32'h0});
    repeat (3) idle();
    check({q.size(), skips}, {32'd0, nskip});
    final_report();
  end
endmodule

// ---- tb/tpx_cpu_model.sv ----
// Accumulator datapath stand-in that keeps results and counts skips
`timescale 1ns/1ns
module tpx_cpu_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Results from the executor
  input  wire logic       acc_wr,
  input  wire logic [3:0] acc_data,
  input  wire logic       b_wr,
  input  wire logic [3:0] b_data,
  input  wire logic       skip_next,
  // Held state
  output logic [3:0]      acc_q,
  output logic [7:0]      skips
);
  // ==========================================================
  // The datapath takes results only on a strobe; B is watched but not kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 4'h0;
      skips <= 8'h00;
    end else begin
      if (acc_wr) acc_q <= acc_data;
      if (skip_next) skips <= skips + 8'h01;
    end
  end
endmodule
